// ==== design/vas_consts.svh ====
// vas_consts: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the slave front end and sequencer
`ifndef VAS_CONSTS_SVH
`define VAS_CONSTS_SVH

// ----------------------------------------
// backplane decode
// ----------------------------------------
`define VAS_AM_SUP 6'h3D
`define VAS_AM_NPRIV 6'h39
`define VAS_VME_STAT_W 17'h00040
`define VAS_DEF_BASE 6'h20
`define VAS_DEF_LVL 3'h0

// ----------------------------------------
// register offsets (apb byte addresses)
// ----------------------------------------
`define VAS_APB_CTRL 8'h00
`define VAS_APB_VECT 8'h04
`define VAS_APB_COUNT 8'h08
`define VAS_APB_PERIOD 8'h0C
`define VAS_APB_SWTRIG 8'h10
`define VAS_APB_STAT 8'h14
`define VAS_APB_SCAN_HI 2'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define VAS_CTRL_GO 0
`define VAS_CTRL_MODE 1
`define VAS_CTRL_SRC 3
`define VAS_CTRL_GIE 5
`define VAS_CTRL_LAST 8
`define VAS_ST_BUSY 0
`define VAS_ST_DONE 1
`define VAS_ST_PEND 2
`define VAS_ST_GIE 3
`define VAS_VST_DONE 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define VAS_CTRL_RST 12'h000
`define VAS_VECT_RST 8'h0F
`define VAS_COUNT_RST 16'h0001
`define VAS_PERIOD_RST 16'h03E7

// ----------------------------------------
// timing
// ----------------------------------------
`define VAS_CLK_MHZ 100
`define VAS_TPUT_NS 10000
`define VAS_TPUT_CYC ((`VAS_TPUT_NS * `VAS_CLK_MHZ) / 1000)

`endif

// ==== design/vas_front.sv ====
// vas_front: backplane slave front end with strapped decode, interrupter,
// apb register file and the acquisition sequencer
// assumes backplane and apb signals synchronous to clock_in
`default_nettype none
`include "vas_consts.svh"

module vas_front
  import vas_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [23:1] vme_addr_in,
  input wire logic [5:0] vme_am_in,
  input wire logic vme_as_n_in,
  input wire logic vme_ds0_n_in,
  input wire logic vme_ds1_n_in,
  input wire logic vme_write_n_in,
  input wire logic vme_lword_n_in,
  input wire logic vme_iack_n_in,
  input wire logic vme_iackin_n_in,
  output logic vme_iackout_n_out,
  input wire logic [15:0] vme_data_in,
  output logic [15:0] vme_data_out,
  output logic vme_data_oe_out,
  output logic vme_dtack_n_out,
  output logic vme_dtack_oe_out,
  output logic [7:1] vme_irq_n_out,
  output logic [7:1] vme_irq_oe_out,
  input wire logic [5:0] base_address_straps_in,
  input wire logic nonpriv_modifier_strap_in,
  input wire logic [2:0] irq_level_straps_in,
  input wire logic input_type_strap_a_in,
  input wire logic input_type_strap_b_in,
  input wire logic twos_complement_format_in,
  output logic adc_start_out,
  output logic [4:0] adc_chan_out,
  output logic [1:0] adc_gain_out,
  input wire logic adc_done_in,
  input wire logic [11:0] adc_data_in,
  input wire logic ext_trig_n_in,
  output logic trig_out,
  output logic mem_wr_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_data_out
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic am_ok(input logic [5:0] am, input logic npriv);
    am_ok = (am == `VAS_AM_SUP) | ((am == `VAS_AM_NPRIV) & npriv);
  endfunction : am_ok

  // identification bytes; the values are arbitrary
  function automatic logic [7:0] id_byte(input logic [4:0] idx);
    id_byte = {3'h2, idx};
  endfunction : id_byte

  logic [5:0] base_q;
  logic npriv_q, se_q, fmt_q;
  logic [2:0] lvl_q;
  logic [11:0] ctrl_q;
  logic [7:0] vector_q;
  logic [15:0] count_q, period_q;
  logic [6:0] scan_q [16];
  logic pend_q, acq_done_q;
  logic ack_q, iak_q, rd_q;
  logic [15:0] vrd_q;
  logic [31:0] prd_q;

  wire busy, blk_done, half_ev;
  wire [3:0] scan_idx;

  // ----------------------------------------
  // straps
  // ----------------------------------------
  // straps are caught while reset is held; moving them later has no effect
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      base_q <= base_address_straps_in;
      npriv_q <= nonpriv_modifier_strap_in;
      lvl_q <= irq_level_straps_in;
      se_q <= input_type_strap_a_in & input_type_strap_b_in;
      fmt_q <= twos_complement_format_in;
    end
  end

  // ----------------------------------------
  // backplane decode
  // ----------------------------------------
  wire vme_cyc = ~vme_as_n_in & (~vme_ds0_n_in | ~vme_ds1_n_in);
  wire base_hit = vme_addr_in[23:18] == base_q;
  wire dtb_hit = vme_cyc & vme_iack_n_in & vme_lword_n_in &
                 am_ok(vme_am_in, npriv_q) & base_hit;
  wire gie = ctrl_q[`VAS_CTRL_GIE];
  wire irq_act = pend_q & gie & (lvl_q != 3'h0);
  wire our_lvl = irq_act & (vme_addr_in[3:1] == lvl_q);
  wire iack_hit = vme_cyc & ~vme_ds0_n_in & ~vme_iack_n_in & ~vme_iackin_n_in & our_lvl;
  wire respond = dtb_hit | iack_hit;
  wire take = respond & ~ack_q;
  wire [16:0] off = vme_addr_in[17:1];
  wire id_sel = off[16:5] == 12'h000;
  wire stat_sel = off == `VAS_VME_STAT_W;
  wire [7:0] stat_byte = {acq_done_q, 3'h0, gie, pend_q, 2'h0};
  // id and status live on the odd lane; the even lane reads zero
  wire [15:0] vrdat = iack_hit ? {8'h00, vector_q} :
                      id_sel ? {8'h00, id_byte(off[4:0])} :
                      stat_sel ? {8'h00, stat_byte} : 16'h0000;
  wire vme_wr_stat = take & dtb_hit & ~vme_write_n_in & stat_sel & ~vme_ds0_n_in;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      iak_q <= 1'b0;
      rd_q <= 1'b0;
      vrd_q <= 16'h0000;
    end else if (take) begin
      ack_q <= 1'b1;
      iak_q <= iack_hit;
      rd_q <= vme_write_n_in | iack_hit;
      vrd_q <= vrdat;
    end else if (vme_ds0_n_in && vme_ds1_n_in) begin
      ack_q <= 1'b0;
      iak_q <= 1'b0;
      rd_q <= 1'b0;
    end
  end

  assign vme_dtack_n_out = ~ack_q;
  assign vme_dtack_oe_out = ack_q;
  assign vme_data_out = vrd_q;
  assign vme_data_oe_out = ack_q & rd_q;
  // daisy chain passes on unless this board claims or holds the acknowledge;
  // the pending flag drops at the claim, so the held cycle must keep it back
  assign vme_iackout_n_out = ~(~vme_iackin_n_in & ~vme_iack_n_in & ~vme_as_n_in &
                               ~our_lvl & ~iak_q);

  // ----------------------------------------
  // request lines
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_irq
      assign vme_irq_oe_out[gi] = irq_act & (lvl_q == 3'(gi));
      assign vme_irq_n_out[gi] = 1'b0;
    end
  endgenerate

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire apb_wr = psel_in & penable_in & pwrite_in;
  wire wr_ctrl = apb_wr & (paddr_in == `VAS_APB_CTRL);
  wire wr_vect = apb_wr & (paddr_in == `VAS_APB_VECT);
  wire wr_count = apb_wr & (paddr_in == `VAS_APB_COUNT);
  wire wr_period = apb_wr & (paddr_in == `VAS_APB_PERIOD);
  wire wr_sw = apb_wr & (paddr_in == `VAS_APB_SWTRIG);
  wire wr_stat = apb_wr & (paddr_in == `VAS_APB_STAT);
  wire scan_sel = (paddr_in[7:6] == `VAS_APB_SCAN_HI) & (paddr_in[1:0] == 2'h0);
  wire wr_scan = apb_wr & scan_sel;
  wire start_p = wr_ctrl & pwdata_in[`VAS_CTRL_GO];
  wire stop_p = wr_ctrl & ~pwdata_in[`VAS_CTRL_GO];
  wire [31:0] stat_word = {28'h0000000, gie, pend_q, acq_done_q, busy};
  wire [31:0] prdat = (paddr_in == `VAS_APB_CTRL) ? {20'h00000, ctrl_q} :
                      (paddr_in == `VAS_APB_VECT) ? {24'h000000, vector_q} :
                      (paddr_in == `VAS_APB_COUNT) ? {16'h0000, count_q} :
                      (paddr_in == `VAS_APB_PERIOD) ? {16'h0000, period_q} :
                      (paddr_in == `VAS_APB_STAT) ? stat_word :
                      scan_sel ? {25'h0000000, scan_q[paddr_in[5:2]]} : 32'h00000000;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) prd_q <= 32'h00000000;
    else if (psel_in && !penable_in) prd_q <= prdat;
  end

  assign prdata_out = prd_q;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) ctrl_q <= `VAS_CTRL_RST;
    else if (wr_ctrl) ctrl_q <= pwdata_in[11:0];
    else if (vme_wr_stat) ctrl_q[`VAS_CTRL_GIE] <= vme_data_in[`VAS_ST_GIE];
    else if (blk_done) ctrl_q[`VAS_CTRL_GO] <= 1'b0;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vector_q <= `VAS_VECT_RST;
      count_q <= `VAS_COUNT_RST;
      period_q <= `VAS_PERIOD_RST;
    end else begin
      if (wr_vect) vector_q <= pwdata_in[7:0];
      if (wr_count) count_q <= pwdata_in[15:0];
      if (wr_period) period_q <= pwdata_in[15:0];
    end
  end

  generate
    for (gi = 0; gi < 16; gi++) begin : g_scan
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) scan_q[gi] <= 7'h00;
        else if (wr_scan && paddr_in[5:2] == 4'(gi)) scan_q[gi] <= pwdata_in[6:0];
      end
    end
  endgenerate

  // ----------------------------------------
  // interrupt and completion flags
  // ----------------------------------------
  // a new event in the clearing cycle keeps the flag set
  wire ev = blk_done | half_ev;
  wire pend_clr = (wr_stat & pwdata_in[`VAS_ST_PEND]) | (take & iack_hit);
  wire done_clr = wr_stat & pwdata_in[`VAS_ST_DONE];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
      acq_done_q <= 1'b0;
    end else begin
      pend_q <= ev | (pend_q & ~pend_clr);
      acq_done_q <= blk_done | (acq_done_q & ~done_clr);
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  vas_seq u_seq (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(start_p),
    .stop_in(stop_p),
    .mode_in(ctrl_q[`VAS_CTRL_MODE+1:`VAS_CTRL_MODE]),
    .src_in(ctrl_q[`VAS_CTRL_SRC+1:`VAS_CTRL_SRC]),
    .count_in(count_q),
    .period_in(period_q),
    .sw_trig_in(wr_sw),
    .ext_trig_n_in(ext_trig_n_in),
    .scan_last_in(ctrl_q[`VAS_CTRL_LAST+3:`VAS_CTRL_LAST]),
    .scan_entry_in(scan_q[scan_idx]),
    .single_ended_in(se_q),
    .twos_in(fmt_q),
    .adc_done_in(adc_done_in),
    .adc_data_in(adc_data_in),
    .scan_idx_out(scan_idx),
    .adc_start_out(adc_start_out),
    .adc_chan_out(adc_chan_out),
    .adc_gain_out(adc_gain_out),
    .trig_out(trig_out),
    .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out),
    .busy_out(busy),
    .block_done_out(blk_done),
    .half_full_out(half_ev)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  wire [7:0] lvl_onehot = 8'h01 << lvl_q;

  property p_ack_cause;
    $rose(ack_q) |-> $past(dtb_hit) || $past(iack_hit);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without decode");

  property p_am;
    $rose(ack_q) && !iak_q |->
      $past(vme_am_in) == `VAS_AM_SUP || ($past(vme_am_in) == `VAS_AM_NPRIV && npriv_q);
  endproperty
  a_am: assert property (p_am) else $error("bad modifier acknowledged");

  property p_base;
    $rose(ack_q) && !iak_q |-> $past(vme_addr_in[23:18]) == base_q;
  endproperty
  a_base: assert property (p_base) else $error("foreign window acknowledged");

  property p_word;
    $rose(ack_q) && !iak_q |-> $past(vme_lword_n_in);
  endproperty
  a_word: assert property (p_word) else $error("long word acknowledged");

  property p_lvl0;
    lvl_q == 3'h0 |-> vme_irq_oe_out == 7'h00;
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("request with no level");

  property p_line;
    pend_q && gie && lvl_q != 3'h0 |-> vme_irq_oe_out == lvl_onehot[7:1];
  endproperty
  a_line: assert property (p_line) else $error("wrong request line");

  property p_roak;
    take && iack_hit && !ev |=> !pend_q && vme_irq_oe_out == 7'h00;
  endproperty
  a_roak: assert property (p_roak) else $error("request kept after ack");

  property p_vector;
    ack_q && iak_q |-> vme_data_out[7:0] == vector_q && vme_data_oe_out;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not driven");

  property p_event;
    ev |=> pend_q;
  endproperty
  a_event: assert property (p_event) else $error("event lost");

  c_iack: cover property (take && iack_hit);
  c_read: cover property (take && dtb_hit && vme_write_n_in && id_sel);
  c_def: cover property (base_q == `VAS_DEF_BASE && lvl_q == `VAS_DEF_LVL && ack_q);
endmodule : vas_front

`default_nettype wire

// ==== design/vas_pkg.sv ====
// vas_pkg: mode, trigger source and sequencer state types
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package vas_pkg;
  typedef enum logic [1:0] {VAS_MODE_BLOCK, VAS_MODE_CONT, VAS_MODE_TSTOP} vas_mode_t;
  typedef enum logic [1:0] {VAS_SRC_TIMER, VAS_SRC_EXT, VAS_SRC_SW} vas_src_t;
  typedef enum {VAS_S_IDLE, VAS_S_WAIT, VAS_S_CONV} vas_state_t;
endpackage : vas_pkg

`default_nettype wire

// ==== design/vas_seq.sv ====
// vas_seq: acquisition sequencer, scan walk, triggers and sample store
// assumes adc and trigger pins synchronous to clock_in
`default_nettype none
`include "vas_consts.svh"

module vas_seq
  import vas_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] src_in,
  input wire logic [15:0] count_in,
  input wire logic [15:0] period_in,
  input wire logic sw_trig_in,
  input wire logic ext_trig_n_in,
  input wire logic [3:0] scan_last_in,
  input wire logic [6:0] scan_entry_in,
  input wire logic single_ended_in,
  input wire logic twos_in,
  input wire logic adc_done_in,
  input wire logic [11:0] adc_data_in,
  output logic [3:0] scan_idx_out,
  output logic adc_start_out,
  output logic [4:0] adc_chan_out,
  output logic [1:0] adc_gain_out,
  output logic trig_out,
  output logic mem_wr_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_data_out,
  output logic busy_out,
  output logic block_done_out,
  output logic half_full_out
);
  localparam int TPUT_MAX = `VAS_TPUT_CYC;
  localparam logic [9:0] CONV_LAST = 10'(`VAS_TPUT_CYC - 1);

  vas_state_t st_q, st_d;
  logic ext_q, armed_q, trig_q, start_q, wr_q, done_q, half_q;
  logic [15:0] tmr_q, cnt_q, addr_q, waddr_q, data_q;
  logic [9:0] ctmr_q;
  logic [3:0] idx_q;
  logic [4:0] chan_q;
  logic [1:0] gain_q;

  // ----------------------------------------
  // triggers
  // ----------------------------------------
  wire busy = st_q != VAS_S_IDLE;
  wire ext_fall = ext_q & ~ext_trig_n_in;
  wire tick = busy & (tmr_q == 16'h0000);
  wire conv_trig = busy & ((src_in == VAS_SRC_TIMER) ? tick :
                   (src_in == VAS_SRC_EXT) ? ext_fall : sw_trig_in);
  wire stop_acc = busy & (mode_in == VAS_MODE_TSTOP) & ~armed_q &
                  (ext_fall | sw_trig_in);
  wire go_conv = (st_q == VAS_S_WAIT) & conv_trig;
  // a missing adc answer still closes the slot, so throughput never slips
  wire store = (st_q == VAS_S_CONV) & (adc_done_in | (ctmr_q == CONV_LAST));
  wire cnting = (mode_in == VAS_MODE_BLOCK) | ((mode_in == VAS_MODE_TSTOP) & armed_q);
  wire fin = store & cnting & (cnt_q == 16'h0001);

  // ----------------------------------------
  // state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      VAS_S_IDLE: if (start_in) st_d = VAS_S_WAIT;
      VAS_S_WAIT: if (go_conv) st_d = VAS_S_CONV;
      VAS_S_CONV: if (fin) st_d = VAS_S_IDLE; else if (store) st_d = VAS_S_WAIT;
      default: st_d = VAS_S_IDLE;
    endcase
    if (stop_in) st_d = VAS_S_IDLE;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) st_q <= VAS_S_IDLE;
    else st_q <= st_d;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ext_q <= 1'b1;
      tmr_q <= 16'h0000;
      ctmr_q <= 10'h000;
      armed_q <= 1'b0;
    end else begin
      ext_q <= ext_trig_n_in;
      tmr_q <= (!busy || tick) ? period_in : tmr_q - 16'h0001;
      ctmr_q <= go_conv ? 10'h000 : ctmr_q + 10'h001;
      armed_q <= busy & (armed_q | stop_acc);
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cnt_q <= 16'h0000;
      addr_q <= 16'h0000;
      idx_q <= 4'h0;
    end else if (start_in && !busy) begin
      cnt_q <= count_in;
      addr_q <= 16'h0000;
      idx_q <= 4'h0;
    end else begin
      if (stop_acc) cnt_q <= count_in;
      else if (store && cnting) cnt_q <= cnt_q - 16'h0001;
      if (store) addr_q <= addr_q + 16'h0001;
      if (store) idx_q <= (idx_q == scan_last_in) ? 4'h0 : idx_q + 4'h1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      chan_q <= 5'h00;
      gain_q <= 2'h0;
    end else if (go_conv) begin
      chan_q <= single_ended_in ? scan_entry_in[4:0] : {1'b0, scan_entry_in[3:0]};
      gain_q <= scan_entry_in[6:5];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      trig_q <= 1'b0;
      start_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      half_q <= 1'b0;
      waddr_q <= 16'h0000;
      data_q <= 16'h0000;
    end else begin
      trig_q <= go_conv | stop_acc;
      start_q <= go_conv;
      wr_q <= store;
      done_q <= fin;
      half_q <= store & (addr_q[14:0] == 15'h7FFF);
      if (store) waddr_q <= addr_q;
      if (store) data_q <= {adc_data_in[11] ^ twos_in, adc_data_in[10:0], 4'h0};
    end
  end

  assign scan_idx_out = idx_q;
  assign adc_start_out = start_q;
  assign adc_chan_out = chan_q;
  assign adc_gain_out = gain_q;
  assign trig_out = trig_q;
  assign mem_wr_out = wr_q;
  assign mem_addr_out = waddr_q;
  assign mem_data_out = data_q;
  assign busy_out = busy;
  assign block_done_out = done_q;
  assign half_full_out = half_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_fmt;
    mem_wr_out |-> mem_data_out[3:0] == 4'h0;
  endproperty
  a_fmt: assert property (p_fmt) else $error("sample low nibble not zero");

  property p_tput;
    go_conv |=> ##[0:TPUT_MAX] (mem_wr_out || st_q == VAS_S_IDLE);
  endproperty
  a_tput: assert property (p_tput) else $error("conversion slot overran");

  property p_trig;
    go_conv |=> trig_out && adc_start_out;
  endproperty
  a_trig: assert property (p_trig) else $error("accepted trigger not echoed");

  property p_ext;
    (st_q == VAS_S_WAIT && src_in == VAS_SRC_EXT && $past(ext_trig_n_in) && !ext_trig_n_in
     && !stop_in) |=> st_q == VAS_S_CONV;
  endproperty
  a_ext: assert property (p_ext) else $error("falling edge missed");

  property p_block;
    fin && !stop_in |=> st_q == VAS_S_IDLE && block_done_out;
  endproperty
  a_block: assert property (p_block) else $error("block did not stop");

  c_block: cover property (block_done_out);
  c_half: cover property (half_full_out);
endmodule : vas_seq

`default_nettype wire

// ==== test/tb.sv ====
// tb: apb and backplane tests of the acquisition front end
// assumes straps are sampled while reset is held
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic pready_out, pslverr_out, vme_iackout_n_out, vme_data_oe_out, vme_dtack_n_out;
  logic vme_dtack_oe_out, adc_start_out, trig_out, mem_wr_out, adc_done_in = 0;
  logic vme_as_n_in, vme_ds0_n_in, vme_iack_n_in, ext_trig_n_in = 1;
  logic nonpriv_modifier_strap_in = 1, twos_complement_format_in = 1;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, prd;
  logic [23:1] vme_addr_in;
  logic [5:0] vme_am_in, base_address_straps_in = 6'h20;
  logic [15:0] vme_data_in, vme_data_out, mem_addr_out, mem_data_out, md, ma;
  logic [7:1] vme_irq_n_out, vme_irq_oe_out;
  logic [2:0] irq_level_straps_in = 3'h0;
  logic [4:0] adc_chan_out;
  logic [1:0] adc_gain_out;
  logic [6:0] cg;
  logic [11:0] adc_data_in = 12'hFFF;
  int n_mismatch = 0, checked = 0, nt = 0, nw = 0, nc = 0, nio = 0;
  vas_front i_dut (.*, .vme_ds1_n_in(1'b1), .vme_write_n_in(1'b1), .vme_lword_n_in(1'b1),
    .vme_iackin_n_in(vme_iack_n_in), .input_type_strap_a_in(1'b0),
    .input_type_strap_b_in(1'b0));
  vas_mst i_mst (.clock_in, .dtack_oe_in(vme_dtack_oe_out), .data_in(vme_data_out),
    .addr_out(vme_addr_in), .am_out(vme_am_in), .as_n_out(vme_as_n_in),
    .ds_n_out(vme_ds0_n_in), .iack_n_out(vme_iack_n_in), .data_out(vme_data_in));
  always #5 clock_in = ~clock_in;
  // converter answers one cycle after each start
  always @(posedge clock_in) begin
    adc_done_in <= adc_start_out;
    if (adc_start_out) cg <= {adc_gain_out, adc_chan_out};
    if (trig_out) nt++;
    if (mem_wr_out) nw++;
    if (mem_wr_out) {md, ma} <= {mem_data_out, mem_addr_out};
    // every cycle here is a read on our own level, so nothing may pass down
    if (!sys_rst_in && (!vme_iackout_n_out || vme_dtack_n_out === vme_dtack_oe_out ||
        vme_data_oe_out !== vme_dtack_oe_out)) nio++;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    prd = prdata_out;
    {psel_in, penable_in} <= 2'h0;
    @(posedge clock_in);
  endtask : ap
  task automatic vr(input logic [23:0] a, input logic [5:0] m, input logic ia, ea,
      input logic [7:0] ed);
    logic ak;
    logic [15:0] d;
    i_mst.cyc(a[23:1], m, ia, ak, d);
    chk(ak, ea);
    if (ea) chk(d[7:0], ed);
  endtask : vr
  task automatic print_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    ap(1'b0, 8'h04, 32'h0);
    chk(prd, 32'h0000000F);
    ap(1'b0, 8'hF0, 32'h0);
    chk(prd, 32'h0);
    chk(pslverr_out, 1'b0);
    vr(24'h800001, 6'h3D, 1'b1, 1'b1, 8'h40);
    vr(24'h80003F, 6'h39, 1'b1, 1'b1, 8'h5F);
    vr(24'h800001, 6'h09, 1'b1, 1'b0, 8'h00);
    vr(24'h7C0001, 6'h3D, 1'b1, 1'b0, 8'h00);
    ap(1'b1, 8'h40, 32'h00000065);
    ap(1'b1, 8'h08, 32'h00000002);
    ap(1'b1, 8'h00, 32'h00000031);
    // third trigger lands after the block is over and must be ignored
    repeat (3) begin
      ap(1'b1, 8'h10, 32'h0);
      repeat (4) @(posedge clock_in);
    end
    chk(nw, 2);
    chk(nt, 2);
    chk(cg, 7'h65);
    chk(md, 16'h7FF0);
    chk(ma, 16'h0001);
    ap(1'b0, 8'h14, 32'h0);
    chk(prd[2:0], 3'h6);
    chk(vme_irq_oe_out, 7'h00);
    sys_rst_in <= 1'b1;
    base_address_straps_in <= 6'h3F;
    nonpriv_modifier_strap_in <= 1'b0;
    irq_level_straps_in <= 3'h3;
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    ap(1'b0, 8'h14, 32'h0);
    chk(prd[2:0], 3'h0);
    vr(24'hFC0001, 6'h3D, 1'b1, 1'b1, 8'h40);
    vr(24'hFC0001, 6'h39, 1'b1, 1'b0, 8'h00);
    ap(1'b1, 8'h04, 32'h000000A5);
    ap(1'b1, 8'h00, 32'h00000029);
    ext_trig_n_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    ext_trig_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk(nt, 3);
    chk(vme_irq_oe_out, 7'h04);
    chk(vme_irq_n_out, 7'h00);
    vr(24'h000006, 6'h3D, 1'b0, 1'b1, 8'hA5);
    chk(vme_irq_oe_out, 7'h00);
    chk(nio, 0);
    // timer-paced continuous run, then a stop
    ap(1'b1, 8'h0C, 32'h00000008);
    ap(1'b1, 8'h00, 32'h00000003);
    repeat (100) @(posedge clock_in);
    ap(1'b0, 8'h14, 32'h0);
    chk(prd[0], 1'b1);
    chk(nw > 10, 1'b1);
    ap(1'b1, 8'h00, 32'h00000000);
    ap(1'b1, 8'h14, 32'h00000002);
    ap(1'b0, 8'h14, 32'h0);
    chk(prd[1:0], 2'h0);
    nc = nt - nw;
    // trigger-stop: timer conversions before, a software write arms the stop
    ap(1'b1, 8'h08, 32'h00000003);
    ap(1'b1, 8'h00, 32'h00000005);
    repeat (30) @(posedge clock_in);
    ap(1'b1, 8'h10, 32'h0);
    repeat (60) @(posedge clock_in);
    ap(1'b0, 8'h14, 32'h0);
    chk(prd[1:0], 2'h2);
    chk(nt - nw, nc + 1);
    nc = nw;
    repeat (30) @(posedge clock_in);
    chk(nw, nc);
    print_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// ==== test/vas_mst.sv ====
// vas_mst: backplane master and interrupt handler model
// assumes the board answers on rising clock_in
`default_nettype none
module vas_mst (
  input wire logic clock_in,
  input wire logic dtack_oe_in,
  input wire logic [15:0] data_in,
  output logic [23:1] addr_out,
  output logic [5:0] am_out,
  output logic as_n_out,
  output logic ds_n_out,
  output logic iack_n_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_out, am_out, as_n_out, ds_n_out, iack_n_out, data_out} = {29'h0, 19'h7FFFF};
  // idle data lines toggle so no stale word passes for an answer
  always @(posedge clock_in) data_out <= ~data_out;
  task automatic cyc(input logic [23:1] a, input logic [5:0] m, input logic ia,
      output logic ak, output logic [15:0] d);
    ak = 1'b0;
    {addr_out, am_out, iack_n_out, as_n_out, ds_n_out} <= {a, m, ia, 2'b00};
    for (int i = 0; i < 8 && !ak; i++) begin
      @(posedge clock_in);
      {ak, d} = {dtack_oe_in, data_in};
    end
    // strobes go high between cycles so the next one is a fresh request
    {iack_n_out, as_n_out, ds_n_out} <= 3'h7;
    repeat (3) @(posedge clock_in);
  endtask : cyc
endmodule : vas_mst
`default_nettype wire
